// ### flashp_core.sv
/*
 * Device-side command front end of a 2 MiB serial NOR flash: link
 * sampling, single/dual/quad/double-rate transfers, four-wire command
 * mode, write-enable latch, deep power-down filter, block protection.
 * Assumes: link pins are asynchronous and much slower than clk_in; the
 * array engine runs on clk_in, answers read_addr_out within one cycle
 * and reports busy_in.
 */
`timescale 1ns/1ns
`include "flashp_map.svh"

// Contract
// - 32 blocks, 16 sectors, 16 pages each
// - accept clock idling low or high
// - sample on rise, shift out on fall
// - dual reads use lines 0 and 1
// - quad reads use all four lines
// - double-rate quad read uses both edges
// - quad enable bit always reads one
// - four-wire mode switched only by its opcodes
// - four-wire mode takes opcodes four bits/clock
// - power-up and reset select normal SPI
// - write enable sets the latch
// - latch cleared by reset and modifying commands
// - deep power-down ignores all but wake/reset
// - protected range readable, not programmable
// - complement clear, coarse: blocks top or bottom
// - complement clear, fine: 4K to 32K; field values 6 and 7 protect the whole array
// - complement set inverts the protected range
// - latch clear refuses status write, program, erase
// - complement bit is status bit fourteen
module flashp_core (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// serial link
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic data_line_0_in,
	output logic data_line_0_out,
	output logic data_line_0_oe_out,
	input wire logic data_line_1_in,
	output logic data_line_1_out,
	output logic data_line_1_oe_out,
	input wire logic data_line_2_in,
	output logic data_line_2_out,
	output logic data_line_2_oe_out,
	input wire logic data_line_3_in,
	output logic data_line_3_out,
	output logic data_line_3_oe_out,
	// array engine
	input wire logic busy_in,
	input wire logic [7:0] read_byte_in,
	output logic [20:0] read_addr_out,
	output logic read_next_out,
	output logic pe_start_out,
	output flashp_pkg::flashp_pe_t pe_kind_out,
	output logic [20:0] pe_addr_out,
	// status
	output logic write_enable_latch_out,
	output logic four_wire_command_mode_out,
	output logic power_down_out,
	output logic quad_enable_bit_out,
	output logic [4:0] protect_bits_out,
	output logic protect_complement_bit_out
);
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q, cs_s1_q, cs_s2_q, cs_s3_q;
	logic [3:0] io_s1_q, io_s2_q;
	logic rise, fall, sel, fr_end, fin_ok, oev, rd_op, dp_ok, prot_hit, qpi_cmd;
	flashp_pkg::flashp_state_t st_q, st_d;
	flashp_pkg::flashp_width_t win_q, win_d, wout_q, wout_d;
	flashp_pkg::flashp_pe_t pe_kind_q, pe_kind_d, kind_c;
	logic [7:0] op_q, op_d, dout_q, dout_d, sr1_q, sr1_d, sr2_q, sr2_d;
	logic [7:0] stat1, stat2, src, cur;
	logic [23:0] sh_q, sh_d, sh_n, addr_q, addr_d;
	logic [4:0] cnt_q, cnt_d, cnt_n, nb, nbo, lg_c;
	logic [2:0] tot_q, tot_d, ocnt_q, ocnt_d;
	logic [3:0] out_q, out_d, oe_q, oe_d;
	logic [1:0] nsr_q, nsr_d;
	logic [20:0] base_c, pe_addr_q, pe_addr_d;
	logic dtr_q, dtr_d, wel_q, wel_d, qpi_q, qpi_d, dp_q, dp_d, arm_q, arm_d, cmp_q, cmp_d;
	logic pe_start_q, pe_start_d, rd_next_q, rd_next_d;
	logic [4:0] bp_q, bp_d;

	// link pins are asynchronous: two stages, third only for edge finding
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			io_s1_q <= 4'h0;
			io_s2_q <= 4'h0;
		end else if (ce_in) begin
			sclk_s1_q <= sclk_in;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			cs_s1_q <= cs_n_in;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			io_s1_q <= {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in};
			io_s2_q <= io_s1_q;
		end
	end

	// edges only, so the idle level of the clock never matters
	assign rise = sclk_s2_q && !sclk_s3_q;
	assign fall = !sclk_s2_q && sclk_s3_q;
	assign sel = !cs_s2_q;
	assign fr_end = cs_s2_q && !cs_s3_q;
	assign fin_ok = fr_end && (st_q == flashp_pkg::ST_DIN) && (tot_q == 3'h0);
	assign oev = fall || (dtr_q && rise);
	assign rd_op = (op_q == `FP_READ) || (op_q == `FP_FREAD) || (op_q == `FP_DOR)
		|| (op_q == `FP_DIOR) || (op_q == `FP_QOR) || (op_q == `FP_QIOR) || (op_q == `FP_DTRQ);
	assign dp_ok = (sh_n[7:0] == `FP_RDP) || (sh_n[7:0] == `FP_RSTEN) || (sh_n[7:0] == `FP_RST);
	assign qpi_cmd = fin_ok && ((op_q == `FP_QPIEN) || (op_q == `FP_QPIDIS) || (op_q == `FP_RST));
	assign stat1 = {1'b0, bp_q, wel_q, busy_in};
	assign stat2 = {1'b0, cmp_q, 3'h0, 1'b0, `FP_QE_VALUE, 1'b0};
	assign src = (op_q == `FP_RDSR1) ? stat1 : ((op_q == `FP_RDSR2) ? stat2 : read_byte_in);
	assign nb = 5'h01 << win_q;
	assign nbo = 5'h01 << wout_q;
	assign cnt_n = cnt_q + nb;

	always_comb begin
		kind_c = flashp_pkg::PE_CHIP;
		lg_c = `FP_ARRAY_LG;
		case (op_q)
			`FP_PP: begin
				kind_c = flashp_pkg::PE_PAGE;
				lg_c = `FP_PAGE_LG;
			end
			`FP_SE: begin
				kind_c = flashp_pkg::PE_SECT;
				lg_c = `FP_SECTOR_LG;
			end
			`FP_BE32: begin
				kind_c = flashp_pkg::PE_BLK32;
				lg_c = `FP_BLK32_LG;
			end
			`FP_BE64: begin
				kind_c = flashp_pkg::PE_BLK64;
				lg_c = `FP_BLOCK_LG;
			end
			default: ;
		endcase
		// whole array shifts the mask out to zero, so chip erase starts at 0
		base_c = addr_q[20:0] & ~((21'h1 << lg_c) - 21'h1);
		unique case (win_q)
			flashp_pkg::W2: sh_n = {sh_q[21:0], io_s2_q[1:0]};
			flashp_pkg::W4: sh_n = {sh_q[19:0], io_s2_q};
			default: sh_n = {sh_q[22:0], io_s2_q[0]};
		endcase
	end

	flashp_protect u_protect (
		.bp_in(bp_q),
		.cmp_in(cmp_q),
		.base_in(base_c),
		.size_lg_in(lg_c),
		.hit_out(prot_hit)
	);

	always_comb begin
		st_d = st_q;
		op_d = op_q;
		sh_d = sh_q;
		addr_d = addr_q;
		cnt_d = cnt_q;
		tot_d = tot_q;
		win_d = win_q;
		wout_d = wout_q;
		dtr_d = dtr_q;
		dout_d = dout_q;
		ocnt_d = ocnt_q;
		out_d = out_q;
		oe_d = oe_q;
		wel_d = wel_q;
		qpi_d = qpi_q;
		dp_d = dp_q;
		arm_d = arm_q;
		bp_d = bp_q;
		cmp_d = cmp_q;
		sr1_d = sr1_q;
		sr2_d = sr2_q;
		nsr_d = nsr_q;
		pe_start_d = 1'b0;
		pe_kind_d = pe_kind_q;
		pe_addr_d = pe_addr_q;
		rd_next_d = 1'b0;
		cur = (ocnt_q == 3'h0) ? src : dout_q;
		if (!sel) begin
			st_d = flashp_pkg::ST_IDLE;
			oe_d = 4'h0;
		end else begin
			unique case (st_q)
				flashp_pkg::ST_IDLE: begin
					st_d = flashp_pkg::ST_CMD;
					cnt_d = 5'h00;
					tot_d = 3'h0;
					win_d = qpi_q ? flashp_pkg::W4 : flashp_pkg::W1;
				end
				flashp_pkg::ST_CMD, flashp_pkg::ST_ADDR, flashp_pkg::ST_DIN: if (rise) begin
					sh_d = sh_n;
					cnt_d = cnt_n;
					tot_d = tot_q + nb[2:0];
					if (st_q == flashp_pkg::ST_CMD && cnt_n == `FP_BYTE_BITS) begin
						cnt_d = 5'h00;
						op_d = sh_n[7:0];
						ocnt_d = 3'h0;
						nsr_d = 2'h0;
						dtr_d = 1'b0;
						wout_d = flashp_pkg::W1;
						win_d = flashp_pkg::W1;
						st_d = flashp_pkg::ST_DIN;
						if (dp_q && !dp_ok) begin
							st_d = flashp_pkg::ST_SKIP;
						end else begin
							case (sh_n[7:0])
								`FP_READ, `FP_FREAD, `FP_PP, `FP_SE, `FP_BE32, `FP_BE64: begin
									st_d = flashp_pkg::ST_ADDR;
								end
								`FP_DOR: begin
									st_d = flashp_pkg::ST_ADDR;
									wout_d = flashp_pkg::W2;
								end
								`FP_DIOR: begin
									st_d = flashp_pkg::ST_ADDR;
									win_d = flashp_pkg::W2;
									wout_d = flashp_pkg::W2;
								end
								`FP_QOR: begin
									st_d = flashp_pkg::ST_ADDR;
									wout_d = flashp_pkg::W4;
								end
								`FP_QIOR, `FP_DTRQ: begin
									st_d = flashp_pkg::ST_ADDR;
									win_d = flashp_pkg::W4;
									wout_d = flashp_pkg::W4;
									dtr_d = (sh_n[7:0] == `FP_DTRQ);
								end
								`FP_RDSR1, `FP_RDSR2: st_d = flashp_pkg::ST_DOUT;
								default: ;
							endcase
							if (qpi_q) begin
								win_d = flashp_pkg::W4;
								wout_d = flashp_pkg::W4;
							end
						end
					end else if (st_q == flashp_pkg::ST_ADDR && cnt_n == `FP_ADDR_BITS) begin
						cnt_d = 5'h00;
						addr_d = sh_n;
						st_d = rd_op ? flashp_pkg::ST_DOUT : flashp_pkg::ST_DIN;
					end else if (st_q == flashp_pkg::ST_DIN && cnt_n == `FP_BYTE_BITS) begin
						cnt_d = 5'h00;
						if (op_q == `FP_STATUS_WRITE_CMD && nsr_q == 2'h0) begin
							sr1_d = sh_n[7:0];
							nsr_d = 2'h1;
						end else if (op_q == `FP_STATUS_WRITE_CMD && nsr_q == 2'h1) begin
							sr2_d = sh_n[7:0];
							nsr_d = 2'h2;
						end
					end
				end
				flashp_pkg::ST_DOUT: if (oev) begin
					unique case (wout_q)
						flashp_pkg::W2: begin
							out_d = {2'h0, cur[7:6]};
							oe_d = 4'h3;
						end
						flashp_pkg::W4: begin
							out_d = cur[7:4];
							oe_d = 4'hf;
						end
						default: begin
							out_d = {2'h0, cur[7], 1'b0};
							oe_d = 4'h2;
						end
					endcase
					dout_d = cur << nbo;
					ocnt_d = ocnt_q + nbo[2:0];
					if (ocnt_q == 3'h0 && rd_op) begin
						rd_next_d = 1'b1;
						addr_d = addr_q + 24'h1;
					end
				end
				flashp_pkg::ST_SKIP: ;
			endcase
		end
		if (fin_ok) begin
			arm_d = (op_q == `FP_RSTEN);
			case (op_q)
				`FP_WRITE_ENABLE_CMD: wel_d = 1'b1;
				`FP_WRITE_DISABLE_CMD: wel_d = 1'b0;
				`FP_STATUS_WRITE_CMD: if (wel_q && !busy_in && nsr_q != 2'h0) begin
					bp_d = sr1_q[`FP_BP_LSB +: 5];
					if (nsr_q[1]) begin
						cmp_d = sr2_q[`FP_CMP_POS];
					end
					wel_d = 1'b0;
				end
				`FP_PP, `FP_SE, `FP_BE32, `FP_BE64, `FP_CE1, `FP_CE2: begin
					if (wel_q && !busy_in && !prot_hit) begin
						pe_start_d = 1'b1;
						pe_kind_d = kind_c;
						pe_addr_d = (op_q == `FP_PP) ? addr_q[20:0] : base_c;
						wel_d = 1'b0;
					end
				end
				`FP_DP: dp_d = 1'b1;
				`FP_RDP: dp_d = 1'b0;
				`FP_RST: if (arm_q) begin
					wel_d = 1'b0;
					qpi_d = 1'b0;
					dp_d = 1'b0;
				end
				`FP_QPIEN: qpi_d = 1'b1;
				`FP_QPIDIS: qpi_d = 1'b0;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= flashp_pkg::ST_IDLE;
			op_q <= 8'h00;
			sh_q <= 24'h0;
			addr_q <= 24'h0;
			cnt_q <= 5'h00;
			tot_q <= 3'h0;
			win_q <= flashp_pkg::W1;
			wout_q <= flashp_pkg::W1;
			dtr_q <= 1'b0;
			dout_q <= 8'h00;
			ocnt_q <= 3'h0;
			out_q <= 4'h0;
			oe_q <= 4'h0;
			wel_q <= 1'b0;
			qpi_q <= 1'b0;
			dp_q <= 1'b0;
			arm_q <= 1'b0;
			bp_q <= `FP_BP_RST;
			cmp_q <= `FP_CMP_RST;
			sr1_q <= 8'h00;
			sr2_q <= 8'h00;
			nsr_q <= 2'h0;
			pe_start_q <= 1'b0;
			pe_kind_q <= flashp_pkg::PE_PAGE;
			pe_addr_q <= 21'h0;
			rd_next_q <= 1'b0;
		end else if (ce_in) begin
			st_q <= st_d;
			op_q <= op_d;
			sh_q <= sh_d;
			addr_q <= addr_d;
			cnt_q <= cnt_d;
			tot_q <= tot_d;
			win_q <= win_d;
			wout_q <= wout_d;
			dtr_q <= dtr_d;
			dout_q <= dout_d;
			ocnt_q <= ocnt_d;
			out_q <= out_d;
			oe_q <= oe_d;
			wel_q <= wel_d;
			qpi_q <= qpi_d;
			dp_q <= dp_d;
			arm_q <= arm_d;
			bp_q <= bp_d;
			cmp_q <= cmp_d;
			sr1_q <= sr1_d;
			sr2_q <= sr2_d;
			nsr_q <= nsr_d;
			pe_start_q <= pe_start_d;
			pe_kind_q <= pe_kind_d;
			pe_addr_q <= pe_addr_d;
			rd_next_q <= rd_next_d;
		end
	end

	assign {data_line_3_out, data_line_2_out, data_line_1_out, data_line_0_out} = out_q;
	assign {data_line_3_oe_out, data_line_2_oe_out, data_line_1_oe_out, data_line_0_oe_out} = oe_q;
	assign read_addr_out = addr_q[20:0];
	assign read_next_out = rd_next_q;
	assign pe_start_out = pe_start_q;
	assign pe_kind_out = pe_kind_q;
	assign pe_addr_out = pe_addr_q;
	assign write_enable_latch_out = wel_q;
	assign four_wire_command_mode_out = qpi_q;
	assign power_down_out = dp_q;
	assign quad_enable_bit_out = `FP_QE_VALUE;
	assign protect_bits_out = bp_q;
	assign protect_complement_bit_out = cmp_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_cmd_end(logic [7:0] code);
		ce_in && fin_ok && op_q == code;
	endsequence
	sequence s_sw_reset;
		ce_in && fin_ok && op_q == `FP_RST && arm_q;
	endsequence

	chk_wel_set: assert property (s_cmd_end(`FP_WRITE_ENABLE_CMD) |=> wel_q)
		else $error("write enable did not set the latch");
	chk_wel_clear: assert property (s_cmd_end(`FP_WRITE_DISABLE_CMD) |=> !wel_q)
		else $error("write disable did not clear the latch");
	// rose, not level: a frozen enable would hold the pulse over a cleared latch
	chk_start_needs_wel: assert property ($rose(pe_start_q) |-> $past(wel_q) && !wel_q)
		else $error("write cycle started without the latch");
	chk_prot_block: assert property ($rose(pe_start_q) |-> !$past(prot_hit))
		else $error("write cycle started on a protected region");
	chk_qpi_switch: assert property (ce_in && $changed(qpi_q) |-> $past(qpi_cmd))
		else $error("four-wire mode changed without its opcode");
	chk_soft_reset: assert property (s_sw_reset |=> !qpi_q && !wel_q && !dp_q)
		else $error("reset left four-wire mode, latch or power-down set");
	chk_dp_ignore: assert property (ce_in && dp_q && st_q == flashp_pkg::ST_SKIP
		|=> $stable(wel_q) && !pe_start_q)
		else $error("command acted during deep power-down");
	chk_out_on_fall: assert property (ce_in && !dtr_q && $changed(out_q) |-> $past(fall))
		else $error("output changed away from a falling edge");
	chk_dual_lines: assert property (op_q == `FP_DIOR && !qpi_q && oe_q != 4'h0
		|-> oe_q == 4'h3)
		else $error("dual read drove wrong lines");
	chk_quad_lines: assert property (op_q == `FP_QIOR && oe_q != 4'h0 |-> oe_q == 4'hf)
		else $error("quad read drove wrong lines");
	chk_dtr_rise: assert property (ce_in && st_q == flashp_pkg::ST_DOUT && op_q == `FP_DTRQ
		&& rise |=> ocnt_q == $past(ocnt_q) + 3'h4)
		else $error("double-rate read skipped a rising edge");
	chk_cmp_none: assert property (bp_q[2:0] == 3'h0 |-> prot_hit == cmp_q)
		else $error("empty field not inverted by complement");
	chk_all_prot: assert property (bp_q[2:1] == 2'h3 && !cmp_q |-> prot_hit)
		else $error("full protection let a region through");
endmodule

// ### flashp_map.svh
/*
 * Constants of the serial flash mode and write-protect block: opcodes,
 * array geometry, field lengths and reset values.
 * Assumes: included by its bare name, before flashp_pkg and the modules.
 */
`ifndef FLASHP_MAP_SVH
`define FLASHP_MAP_SVH

// opcodes
`define FP_WRITE_ENABLE_CMD 8'h06
`define FP_WRITE_DISABLE_CMD 8'h04
`define FP_STATUS_WRITE_CMD 8'h01
`define FP_RDSR1 8'h05
`define FP_RDSR2 8'h35
`define FP_READ 8'h03
`define FP_FREAD 8'h0b
`define FP_DOR 8'h3b
`define FP_DIOR 8'hbb
`define FP_QOR 8'h6b
`define FP_QIOR 8'heb
`define FP_DTRQ 8'hed
`define FP_PP 8'h02
`define FP_SE 8'h20
`define FP_BE32 8'h52
`define FP_BE64 8'hd8
`define FP_CE1 8'h60
`define FP_CE2 8'hc7
`define FP_DP 8'hb9
`define FP_RDP 8'hab
`define FP_RSTEN 8'h66
`define FP_RST 8'h99
`define FP_QPIEN 8'h38
`define FP_QPIDIS 8'hff

// geometry, as log2 of bytes
`define FP_PAGE_LG 5'h08
`define FP_SECTOR_LG 5'h0c
`define FP_BLK32_LG 5'h0f
`define FP_BLOCK_LG 5'h10
`define FP_ARRAY_LG 5'h15
// protect granularity: fine steps from 4 KiB, coarse from 64 KiB
`define FP_PROT_FINE_LG 5'h0c
`define FP_PROT_COARSE_LG 5'h10

// field lengths in bits
`define FP_BYTE_BITS 5'h08
`define FP_ADDR_BITS 5'h18

// status fields and reset values
`define FP_BP_LSB 2
`define FP_CMP_POS 6
`define FP_BP_RST 5'h00
`define FP_CMP_RST 1'b0
`define FP_QE_VALUE 1'b1

`endif

// ### flashp_pkg.sv
/*
 * Types of the serial flash mode and write-protect block.
 * Assumes: compiled before every module of the block.
 */
package flashp_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b010,
		ST_DIN = 3'b011,
		ST_DOUT = 3'b100,
		ST_SKIP = 3'b101
	} flashp_state_t;

	// lines used per clock edge: one, two or four
	typedef enum logic [1:0] {
		W1 = 2'b00,
		W2 = 2'b01,
		W4 = 2'b10
	} flashp_width_t;

	typedef enum logic [2:0] {
		PE_PAGE = 3'b000,
		PE_SECT = 3'b001,
		PE_BLK32 = 3'b010,
		PE_BLK64 = 3'b011,
		PE_CHIP = 3'b100
	} flashp_pe_t;

endpackage

// ### flashp_protect.sv
/*
 * Protected-range decoder: tells whether an aligned region touches the
 * area guarded by the block-protect and complement bits.
 * Assumes: base_in is aligned to the region size; purely combinational.
 */
`timescale 1ns/1ns
`include "flashp_map.svh"

module flashp_protect (
	// protection setting
	input wire logic [4:0] bp_in,
	input wire logic cmp_in,
	// target region
	input wire logic [20:0] base_in,
	input wire logic [4:0] size_lg_in,
	// verdict
	output logic hit_out
);
	logic [2:0] sz;
	logic [2:0] step;
	logic [4:0] lg;
	logic none;
	logic all;
	logic [21:0] full;
	logic [21:0] len;
	logic [21:0] lo;
	logic [21:0] hi;
	logic [21:0] rlo;
	logic [21:0] rhi;

	always_comb begin
		sz = bp_in[2:0];
		none = (sz == 3'h0);
		all = (sz[2:1] == 2'h3);
		full = 22'h1 << `FP_ARRAY_LG;
		// fine steps stop at 32 KiB, coarse ones at half the array
		step = (bp_in[4] && sz[2]) ? 3'h3 : (sz - 3'h1);
		lg = (bp_in[4] ? `FP_PROT_FINE_LG : `FP_PROT_COARSE_LG) + {2'h0, step};
		len = all ? full : (22'h1 << lg);
		if (bp_in[3]) begin
			lo = 22'h0;
			hi = len - 22'h1;
		end else begin
			lo = full - len;
			hi = full - 22'h1;
		end
		rlo = {1'b0, base_in};
		rhi = rlo + (22'h1 << size_lg_in) - 22'h1;
		if (cmp_in) begin
			hit_out = none || (rlo < lo) || (rhi > hi);
		end else begin
			hit_out = !none && (rlo <= hi) && (rhi >= lo);
		end
	end
endmodule

// ### flashp_host.sv
/*
 * Host controller model for the serial flash link: frames, shifts bits
 * out on one, two or four lines, samples read data on line 1 or on the same two or four lines.
 * Assumes: the bench resolves each line, with a pull-up where nobody drives.
 */
`timescale 1ns/1ns

module flashp_host (
	// serial link
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] drv_out,
	output logic [3:0] drv_oe_out,
	// resolved lines
	input wire logic [3:0] line_in
);
	logic idle_lvl = 1'b0;

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		drv_out = 4'hf;
		drv_oe_out = 4'h0;
	end

	// clock stands at the idle level between frames
	task automatic set_mode(input logic m3);
		idle_lvl = m3;
		sclk_out = m3;
		#80;
	endtask

	task automatic start();
		cs_n_out = 1'b0;
		#40;
	endtask

	// data set while sclk is low, taken by the device on the rise
	task automatic put(input logic [31:0] v, input int n, input int w);
		for (int i = n; i > 0; i -= w) begin
			sclk_out = 1'b0;
			drv_oe_out = 4'((1 << w) - 1);
			drv_out = 4'((v >> (i - w)) & ((1 << w) - 1));
			#40;
			sclk_out = 1'b1;
			#40;
		end
	endtask

	function automatic logic [3:0] pick(input int w);
		return (w == 1) ? {3'h0, line_in[1]} : (w == 2) ? {2'h0, line_in[1:0]} : line_in;
	endfunction

	// sampled at the end of each high phase, and of each low phase in double rate, while the last output still stands
	task automatic get(output logic [31:0] v, input int n, input int w, input logic dtr);
		v = '0;
		drv_oe_out = 4'h0;
		for (int i = 0; i < n; i += dtr ? 2 * w : w) begin
			sclk_out = 1'b0;
			#40;
			if (dtr)
				v = (v << w) | 32'(pick(w));
			sclk_out = 1'b1;
			#40;
			v = (v << w) | 32'(pick(w));
		end
	endtask

	task automatic stop();
		sclk_out = idle_lvl;
		drv_oe_out = 4'h0;
		#40;
		cs_n_out = 1'b1;
		#80;
	endtask
endmodule

// ### flashp_tb.sv
/*
 * Self-checking bench for flashp_core: host model on the link and a
 * behavioural array engine whose byte is a function of the address.
 * Assumes: flashp_pkg is compiled first.
 */
`timescale 1ns/1ns

module testbench;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic busy_in = 1'b0;
	logic ce = 1'b1;
	logic rd_nx;
	int nexts = 0;
	logic sclk;
	logic cs_n;
	logic [3:0] h_drv;
	logic [3:0] h_oe;
	wire logic [3:0] d_o;
	wire logic [3:0] d_e;
	wire logic [3:0] line;
	logic [20:0] raddr;
	logic [20:0] pe_addr;
	flashp_pkg::flashp_pe_t pe_kind;
	logic pe_start, write_enable_latch, fw, pd, qe, cmp;
	logic [4:0] bp;
	int errors = 0;
	int checks = 0;
	int starts = 0;
	int cycles = 0;
	int ow = 1;

	// released lines float up to the pull-up level
	assign line = (d_e & d_o) | (~d_e & h_oe & h_drv) | (~d_e & ~h_oe);

	flashp_host host (.sclk_out(sclk), .cs_n_out(cs_n), .drv_out(h_drv), .drv_oe_out(h_oe),
		.line_in(line));

	flashp_core dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .sclk_in(sclk), .cs_n_in(cs_n),
		.data_line_0_in(line[0]), .data_line_0_out(d_o[0]), .data_line_0_oe_out(d_e[0]),
		.data_line_1_in(line[1]), .data_line_1_out(d_o[1]), .data_line_1_oe_out(d_e[1]),
		.data_line_2_in(line[2]), .data_line_2_out(d_o[2]), .data_line_2_oe_out(d_e[2]),
		.data_line_3_in(line[3]), .data_line_3_out(d_o[3]), .data_line_3_oe_out(d_e[3]),
		.busy_in(busy_in), .read_byte_in(raddr[7:0] ^ 8'ha5), .read_addr_out(raddr),
		.read_next_out(rd_nx), .pe_start_out(pe_start), .pe_kind_out(pe_kind),
		.pe_addr_out(pe_addr),
		.write_enable_latch_out(write_enable_latch), .four_wire_command_mode_out(fw), .power_down_out(pd),
		.quad_enable_bit_out(qe), .protect_bits_out(bp), .protect_complement_bit_out(cmp)
	);

	initial begin
		forever #4 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		if (pe_start === 1'b1)
			starts++;
		if (rd_nx === 1'b1)
			nexts++;
		cycles++;
		if (cycles == 60000) begin
			errors++;
			close_out();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic fr(input logic [7:0] op, input logic [31:0] a = 0, input int na = 0,
			input int aw = 1, input logic [31:0] d = 0, input int nd = 0);
		host.start();
		host.put(32'(op), 8, ow);
		if (na > 0)
			host.put(a, na, aw);
		if (nd > 0)
			host.put(d, nd, ow);
		host.stop();
	endtask

	task automatic rd(input logic [7:0] op, input int na, input int aw, input int dw,
			input logic dtr, input int n, output logic [31:0] v);
		host.start();
		host.put(32'(op), 8, ow);
		if (na > 0)
			host.put(32'h107e, na, aw);
		host.get(v, n, dw, dtr);
		host.stop();
	endtask

	task automatic set_prot(input logic [4:0] b, input logic c);
		fr(8'h06);
		fr(8'h01, 0, 0, 1, {17'h0, b, 3'h0, c, 6'h0}, 16);
	endtask

	task automatic t_reset();
		check(write_enable_latch, 0);
		check(fw, 0);
		check({pd, qe, cmp, bp}, 8'h40);
		check({d_e, pe_start, 3'(pe_kind)}, 0);
		check(raddr, 0);
	endtask

	task automatic t_wel();
		// a frame seen while the enable is low must leave no trace
		ce = 1'b0;
		fr(8'h06);
		ce = 1'b1;
		check(write_enable_latch, 0);
		host.set_mode(1'b1);
		fr(8'h06);
		check(write_enable_latch, 1);
		fr(8'h04);
		check(write_enable_latch, 0);
		host.set_mode(1'b0);
		fr(8'h06);
		host.start();
		host.put(32'h04, 7, 1);
		host.stop();
		check(write_enable_latch, 1);
		fr(8'h04);
	endtask

	task automatic t_status();
		logic [31:0] v;
		fr(8'h01, 0, 0, 1, 32'h4c40, 16);
		check(bp, 0);
		set_prot(5'h13, 1'b1);
		check({cmp, bp, write_enable_latch, qe}, 8'hcd);
		rd(8'h05, 0, 1, 1, 0, 8, v);
		check(v, 32'h4c);
		rd(8'h35, 0, 1, 1, 0, 8, v);
		check(v, 32'h42);
	endtask

	task automatic t_prot();
		logic [27:0] tc [21] = '{28'h03f0000, 28'h83ef000, 28'h1200000, 28'h9210000,
			28'h23ff000, 28'ha3fe000, 28'h3200000, 28'hb201000, 28'h0b00000, 28'h8aff000,
			28'h29f8000, 28'ha9f7000, 28'h43ef000, 28'hc3f0000, 28'hb000000, 28'h7000000,
			28'h0c00000, 28'hcc00000,
			28'h41ff000, 28'h63fe000, 28'he3ff000};
		int s0;
		logic [31:0] v;
		foreach (tc[i]) begin
			set_prot(tc[i][25:21], tc[i][26]);
			fr(8'h06);
			s0 = starts;
			fr(8'h20, 32'(tc[i][20:0]), 24);
			check(starts - s0, 32'(tc[i][27]));
			check(write_enable_latch, !tc[i][27]);
			if (tc[i][27])
				check(pe_addr, tc[i][20:0]);
		end
		rd(8'h03, 24, 1, 1, 0, 8, v);
		check(v, 8'h7e ^ 8'ha5);
		set_prot(5'h00, 1'b0);
	endtask

	task automatic t_kinds();
		logic [7:0] op [6] = '{8'h02, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
		logic [20:0] ea [6] = '{21'h123456, 21'h123000, 21'h120000, 21'h120000, 21'h0, 21'h0};
		int s0;
		logic [31:0] v;
		s0 = starts;
		fr(8'h20, 32'h123456, 24);
		check(starts - s0, 0);
		foreach (op[i]) begin
			fr(8'h06);
			s0 = starts;
			fr(op[i], 32'h123456, (i < 4) ? 24 : 0, 1, 32'h3c, (i == 0) ? 8 : 0);
			check({24'(starts - s0), 8'(pe_kind)}, {24'h1, 8'((i < 4) ? i : 4)});
			check(pe_addr, ea[i]);
			check(write_enable_latch, 0);
		end
		@(negedge clk_in) busy_in = 1'b1;
		fr(8'h06);
		s0 = starts;
		fr(8'h20, 32'h0, 24);
		rd(8'h05, 0, 1, 1, 0, 8, v);
		check({24'(starts - s0), v[7:0]}, 32'h03);
		@(negedge clk_in) busy_in = 1'b0;
		fr(8'h04);
	endtask

	task automatic t_read();
		logic [7:0] op [6] = '{8'h03, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'hed};
		int aw [6] = '{1, 1, 1, 2, 4, 4};
		int dw [6] = '{1, 2, 4, 2, 4, 4};
		int n0;
		logic [31:0] v;
		foreach (op[i]) begin
			n0 = nexts;
			rd(op[i], 24, aw[i], dw[i], i == 5, 16, v);
			check(v, {16'h0, 8'h7e ^ 8'ha5, 8'h7f ^ 8'ha5});
			// the host's closing fall opens a third byte before deselect
			check(nexts - n0, 3);
			check(raddr, 21'h107e + 21'h3);
		end
	endtask

	task automatic t_qpi();
		fr(8'h38);
		check(fw, 1);
		ow = 4;
		fr(8'h06);
		check(write_enable_latch, 1);
		fr(8'hff);
		check(fw, 0);
		ow = 1;
		fr(8'h38);
		ow = 4;
		fr(8'h66);
		fr(8'h99);
		ow = 1;
		check({fw, write_enable_latch}, 0);
	endtask

	task automatic t_pd();
		fr(8'hb9);
		fr(8'h06);
		fr(8'h38);
		fr(8'h99);
		check({pd, fw, write_enable_latch}, 3'h4);
		fr(8'hab);
		check(pd, 0);
		fr(8'h06);
		fr(8'hb9);
		fr(8'h66);
		fr(8'h99);
		check({pd, write_enable_latch}, 0);
		// mid-run reset with latch and four-wire mode both set
		fr(8'h06);
		fr(8'h38);
		@(negedge clk_in) rst_n_in = 1'b0;
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge clk_in);
		t_reset();
	endtask

	task automatic done(input string name);
		$display("test %s ended, errors %0d", name, errors);
	endtask

	task automatic close_out();
		$display("checks %0d, errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge clk_in);
		t_reset();
		done("reset");
		t_wel();
		done("latch");
		t_status();
		done("status");
		t_prot();
		done("protect");
		t_kinds();
		done("kinds");
		t_read();
		done("read");
		t_qpi();
		done("four_wire");
		t_pd();
		done("power_down");
		close_out();
	end
endmodule
